// File: hw/icds_regs.vh
`ifndef ICDS_REGS_VH
`define ICDS_REGS_VH

// ==========================================================================
// Slave address and register map
// ==========================================================================
`define ICDS_SLAVE_BASE      7'h48
`define ICDS_REG_CH0         8'hF8
`define ICDS_REG_CH1         8'hF9
`define ICDS_REG_CH2         8'hFA
`define ICDS_REG_CH3         8'hFB
`define ICDS_REG_RESET       8'h00
`define ICDS_DIR_BIT         7
`define ICDS_MAG_MSB         6
`define ICDS_MAG_FULL        7'h7F
`define ICDS_ADDR_RW_BIT     0
`define ICDS_BIT_LAST        3'h7

`endif

// File: hw/icds_slave.v
// Function
// R1 - Answer slave address 90h/92h/94h/96h selected by the two straps.
// R2 - Channel registers live at memory addresses F8h through FBh.
// R3 - Bit 7 is direction: 0 sink, 1 source; resets to 0.
// R4 - Bits 6..0 are magnitude; zero magnitude gives zero current.
// R5 - Output magnitude is code/127 of full scale, direction from bit 7.
// R6 - SDA falling while SCL high is detected as START.
// R7 - SDA rising while SCL high is detected as STOP.
// R8 - Repeated START is accepted like a normal START.
// R9 - Incoming bits sampled on rising SCL; SDA changes only while SCL low.
// R10 - Read data bits are driven at the preceding falling SCL edge.
// R11 - Master makes all SCL pulses and releases SDA for slave bits.
// R12 - Ninth bit acknowledges; slave acks writes, master acks reads.
// R13 - Master NACK ends a read; slave then releases SDA.
// R14 - Bus is idle with SDA and SCL high between STOP and START.
// R15 - Bytes go MSB first; address byte holds 7-bit address and R/W bit.
// R16 - On address mismatch ignore the bus until the next START.
// R17 - Write: address byte, memory address, one data byte, STOP.
// R18 - Read: address byte with read flag, one data byte, NACK, STOP.
// R19 - A read returns the register at the last written memory address.
// R20 - Writes outside F8h..FBh are acknowledged but change nothing.
`timescale 1ns/1ps
`default_nettype none
`include "icds_regs.vh"

module icds_slave (
   input  wire       i_mclk,
   input  wire       i_srst,
   input  wire       i_scl,
   input  wire       i_sda,
   output reg        o_sda_out,
   output reg        o_sda_oe,
   input  wire       i_low_address_strap,
   input  wire       i_high_address_strap,
   output reg  [7:0] o_ch0_setting,
   output reg  [7:0] o_ch1_setting,
   output reg  [7:0] o_ch2_setting,
   output reg  [7:0] o_ch3_setting,
   output reg        o_bus_idle
);
   // ==========================================================================
   // States
   // ==========================================================================
   localparam ST_IDLE = 6'h01;
   localparam ST_ADDR = 6'h02;
   localparam ST_MEMA = 6'h04;
   localparam ST_DATA = 6'h08;
   localparam ST_READ = 6'h10;
   localparam ST_IGN  = 6'h20;

   wire [3:0] sync_w;
   reg        scl_q_r;
   reg        sda_q_r;
   reg  [5:0] state_r;
   reg  [2:0] bit_r;
   reg        ack_phase_r;
   reg  [7:0] shift_r;
   reg  [7:0] mem_addr_r;
   reg  [7:0] tx_r;
   reg  [1:0] strap_r;
   reg        drive_ack_r;

   // Straps are static pins, so they go through the same synchroniser.
   icds_sync #(.WIDTH(4)) u_sync (
      .i_mclk  (i_mclk),
      .i_srst  (i_srst),
      .i_async ({i_scl, i_sda, i_high_address_strap, i_low_address_strap}),
      .o_sync  (sync_w)
   );

   // The edge flops sit behind the synchroniser, so START and STOP show up
   // about three clocks after the pins move; each SCL phase must be longer.
   wire scl_s = sync_w[3];
   wire sda_s = sync_w[2];
   wire scl_rise = scl_s & ~scl_q_r;
   wire scl_fall = ~scl_s & scl_q_r;
   wire start_det = scl_s & scl_q_r & sda_q_r & ~sda_s; // R6 R8
   wire stop_det  = scl_s & scl_q_r & ~sda_q_r & sda_s; // R7
   wire [7:0] rx_byte = {shift_r[6:0], sda_s};

   // ==========================================================================
   // Register map decode
   // ==========================================================================
   // One-hot channel select shared by the read mux and the write strobes.
   // An unmapped address selects nothing, so both paths drop it alike.
   function [3:0] reg_hit;
      input [7:0] addr;
      begin
         if (addr == `ICDS_REG_CH0)
            reg_hit = 4'h1;
         else if (addr == `ICDS_REG_CH1)
            reg_hit = 4'h2;
         else if (addr == `ICDS_REG_CH2)
            reg_hit = 4'h4;
         else if (addr == `ICDS_REG_CH3)
            reg_hit = 4'h8;
         else
            reg_hit = 4'h0;
      end
   endfunction

   function [7:0] reg_sel;
      input [7:0] addr;
      reg   [3:0] hit;
      begin
         hit = reg_hit(addr);
         if (hit[0])
            reg_sel = o_ch0_setting;
         else if (hit[1])
            reg_sel = o_ch1_setting;
         else if (hit[2])
            reg_sel = o_ch2_setting;
         else if (hit[3])
            reg_sel = o_ch3_setting;
         else
            reg_sel = `ICDS_REG_RESET;
      end
   endfunction

   wire [3:0] wr_hit_w = reg_hit(mem_addr_r);

   // ==========================================================================
   // Protocol engine
   // ==========================================================================
   always @(posedge i_mclk) begin
      if (i_srst) begin
         scl_q_r       <= 1'b1;
         sda_q_r       <= 1'b1;
         state_r       <= ST_IDLE;
         bit_r         <= 3'h0;
         ack_phase_r   <= 1'b0;
         shift_r       <= 8'h00;
         mem_addr_r    <= 8'h00;
         tx_r          <= 8'h00;
         strap_r       <= 2'b00;
         drive_ack_r   <= 1'b0;
         o_sda_out     <= 1'b0;
         o_sda_oe      <= 1'b0;
         o_bus_idle    <= 1'b1;
         o_ch0_setting <= `ICDS_REG_RESET; // R3
         o_ch1_setting <= `ICDS_REG_RESET;
         o_ch2_setting <= `ICDS_REG_RESET;
         o_ch3_setting <= `ICDS_REG_RESET;
      end else begin
         scl_q_r <= scl_s;
         sda_q_r <= sda_s;
         strap_r <= sync_w[1:0];
         if (start_det) begin
            state_r     <= ST_ADDR; // R8 R16
            bit_r       <= 3'h0;
            ack_phase_r <= 1'b0;
            o_sda_oe    <= 1'b0;
            o_bus_idle  <= 1'b0;
         end else if (stop_det) begin
            state_r    <= ST_IDLE;
            o_sda_oe   <= 1'b0;
            o_bus_idle <= 1'b1; // R14
         end else if (scl_rise && !ack_phase_r) begin
            shift_r <= rx_byte; // R9 R15
            if (bit_r == `ICDS_BIT_LAST)
               ack_phase_r <= 1'b1;
            bit_r <= bit_r + 3'h1;
         end else if (scl_rise && ack_phase_r) begin
            if (state_r == ST_READ && sda_s)
               state_r <= ST_IGN; // R13
         end else if (scl_fall && ack_phase_r && !drive_ack_r && bit_r == 3'h0) begin
            // End of the eighth bit: decide the ninth.
            drive_ack_r <= 1'b1;
            case (state_r)
               ST_ADDR: begin
                  if (shift_r[7:1] == (`ICDS_SLAVE_BASE | {5'h00, strap_r})) begin // R1
                     o_sda_oe  <= 1'b1; // R12
                     o_sda_out <= 1'b0;
                     state_r   <= shift_r[`ICDS_ADDR_RW_BIT] ? ST_READ : ST_MEMA;
                     tx_r      <= reg_sel(mem_addr_r); // R19
                  end else begin
                     state_r   <= ST_IGN; // R16
                  end
               end
               ST_MEMA: begin
                  o_sda_oe   <= 1'b1;
                  o_sda_out  <= 1'b0;
                  // The pointer outlives STOP, so a later read frame returns this register.
                  mem_addr_r <= shift_r; // R19
                  state_r    <= ST_DATA;
               end
               ST_DATA: begin
                  o_sda_oe  <= 1'b1; // R20
                  o_sda_out <= 1'b0;
                  // Unmapped addresses hit nothing, yet the byte is still acknowledged.
                  if (wr_hit_w[0]) // R2 R4 R5
                     o_ch0_setting <= shift_r;
                  if (wr_hit_w[1])
                     o_ch1_setting <= shift_r;
                  if (wr_hit_w[2])
                     o_ch2_setting <= shift_r;
                  if (wr_hit_w[3])
                     o_ch3_setting <= shift_r;
               end
               ST_READ: begin
                  // Master acks this byte; slave leaves SDA free (R11).
                  o_sda_oe <= 1'b0;
               end
               default: begin
                  o_sda_oe <= 1'b0;
               end
            endcase
         end else if (scl_fall && ack_phase_r && drive_ack_r) begin
            // End of the ninth bit.
            drive_ack_r <= 1'b0;
            ack_phase_r <= 1'b0;
            if (state_r == ST_READ) begin
               o_sda_oe  <= 1'b1; // R10
               o_sda_out <= tx_r[7];
               tx_r      <= {tx_r[6:0], 1'b0};
            end else begin
               o_sda_oe  <= 1'b0;
            end
         end else if (scl_fall && !ack_phase_r && state_r == ST_READ && bit_r != 3'h0) begin
            o_sda_out <= tx_r[7]; // R10
            tx_r      <= {tx_r[6:0], 1'b0};
         end else if (scl_fall && ack_phase_r && state_r == ST_READ) begin
            o_sda_oe <= 1'b0;
         end
      end
   end
endmodule // icds_slave

`default_nettype wire

// File: hw/icds_sync.v
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Two-flop synchroniser for a group of asynchronous levels
// ==========================================================================
module icds_sync #(
   parameter WIDTH = 2
) (
   input  wire             i_mclk,
   input  wire             i_srst,
   input  wire [WIDTH-1:0] i_async,
   output reg  [WIDTH-1:0] o_sync
);
   reg [WIDTH-1:0] meta_r;

   always @(posedge i_mclk) begin
      if (i_srst) begin
         meta_r <= {WIDTH{1'b1}};
         o_sync <= {WIDTH{1'b1}};
      end else begin
         meta_r <= i_async;
         o_sync <= meta_r;
      end
   end
endmodule // icds_sync

`default_nettype wire

// File: testbench/icds_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Pin-level checks of the slave
// ==========================================================================
module icds_chk (
   input wire       i_mclk,
   input wire       i_srst,
   input wire       i_scl,
   input wire       i_sda,
   input wire       o_sda_out,
   input wire       o_sda_oe,
   input wire       o_bus_idle,
   input wire [7:0] o_ch0_setting,
   input wire [7:0] o_ch1_setting,
   input wire [7:0] o_ch2_setting,
   input wire [7:0] o_ch3_setting
);
   wire [31:0] chs = {o_ch0_setting, o_ch1_setting, o_ch2_setting, o_ch3_setting};
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_srst);
   sequence s_start; $fell(i_sda) && i_scl; endsequence
   sequence s_stop; $rose(i_sda) && i_scl; endsequence
   property p_rst; $fell(i_srst) |-> chs == 32'h0 && o_bus_idle && !o_sda_oe; endproperty
   property p_start; s_start |-> ##[1:8] !o_bus_idle; endproperty
   property p_stop; s_stop |-> ##[1:8] o_bus_idle; endproperty
   property p_idle; o_bus_idle |-> !o_sda_oe; endproperty
   property p_oe_edge; $changed(o_sda_oe) |-> !i_scl; endproperty
   property p_hold; o_sda_oe && i_scl && $past(i_scl) |-> $stable(o_sda_out); endproperty
   property p_write; !$stable(chs) |-> !o_bus_idle && !i_scl; endproperty
   property p_drive; $rose(o_sda_oe) |=> o_sda_oe [*8]; endproperty
   a_rst: assert property (p_rst) else $error("bad state after reset");
   a_start: assert property (p_start) else $error("start not seen");
   a_stop: assert property (p_stop) else $error("stop not seen");
   a_idle: assert property (p_idle) else $error("drive while idle");
   a_oe_edge: assert property (p_oe_edge) else $error("drive changed with scl high");
   a_hold: assert property (p_hold) else $error("data moved with scl high");
   a_write: assert property (p_write) else $error("setting changed off a write");
   a_drive: assert property (p_drive) else $error("drive too short");
endmodule // icds_chk
`default_nettype wire

// File: testbench/icds_master.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Bus master model
// ==========================================================================
// SCL rests high between frames; SDA is only released, never driven high.
module icds_master (
   input  wire i_mclk,
   input  wire i_sda,
   output reg  o_scl,
   output reg  o_sda
);
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   // Each quarter of a bit is six clocks, plus one more in the high half,
   // so a bit lasts 25 clocks and SCL runs at a 125 ns period.
   task wt;
      repeat (6) @(negedge i_mclk);
   endtask
   task bitx(input logic b, output logic r);
      o_sda = b;
      wt;
      o_scl = 1'b1;
      wt;
      r = i_sda;
      wt;
      @(negedge i_mclk);
      o_scl = 1'b0;
      wt;
   endtask
   task start;
      o_sda = 1'b1;
      wt;
      o_scl = 1'b1;
      wt;
      o_sda = 1'b0;
      wt;
      o_scl = 1'b0;
      wt;
   endtask
   task stop;
      o_sda = 1'b0;
      wt;
      o_scl = 1'b1;
      wt;
      o_sda = 1'b1;
      wt;
   endtask
   task wbyte(input logic [7:0] d, output logic ack);
      integer i;
      for (i = 7; i >= 0; i--)
         bitx(d[i], ack);
      bitx(1'b1, ack);
   endtask
   task rbyte(input logic nak, output logic [7:0] d);
      integer i;
      logic   r;
      for (i = 7; i >= 0; i--)
         bitx(1'b1, d[i]);
      bitx(nak, r);
   endtask
endmodule // icds_master
`default_nettype wire

// File: testbench/icds_slave_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin err_count++; \
   $display("wrong value %s expected %h seen %h", n, e, s); end end
module icds_slave_tb;
   reg         i_mclk = 0, i_srst = 1, ack;
   reg   [1:0] strap = 0;
   reg   [7:0] mdl [0:3];
   reg   [7:0] a, m, d, rd;
   wire        scl, sda_m, sda_out, sda_oe, idle;
   wire  [7:0] ch [0:3];
   wire        sda = sda_m & (sda_oe ? sda_out : 1'b1);
   integer     err_count = 0, cmp_count = 0, seed = 98788, i, k;
   icds_master mst (.i_mclk(i_mclk), .i_sda(sda), .o_scl(scl), .o_sda(sda_m));
   icds_slave dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_scl(scl), .i_sda(sda),
      .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_low_address_strap(strap[0]),
      .i_high_address_strap(strap[1]), .o_ch0_setting(ch[0]), .o_ch1_setting(ch[1]),
      .o_ch2_setting(ch[2]), .o_ch3_setting(ch[3]), .o_bus_idle(idle));
   task tally_and_finish;
      if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial forever #2.5 i_mclk = ~i_mclk;
   initial begin
      #200000 err_count++;
      tally_and_finish;
   end
   initial begin
      for (i = 0; i < 4; i++) mdl[i] = 8'h00;
      repeat (8) @(negedge i_mclk);
      i_srst = 1'b0;
      repeat (8) @(negedge i_mclk);
      for (i = 0; i < 4; i++) `CHK("reset", 8'h00, ch[i])
      for (k = 0; k < 12; k++) begin
         strap = $random(seed);
         // Pass five uses an address no strap setting can give.
         a = (k == 5) ? 8'h98 : {5'b10010, strap, 1'b0};
         m = 8'hF8 | ($random(seed) & 8'h07);
         d = $random(seed);
         mst.start;
         mst.wbyte(a, ack);
         `CHK("address ack", k == 5, ack)
         if (k != 5) begin
            mst.wbyte(m, ack);
            `CHK("memory ack", 1'b0, ack)
            mst.wbyte(d, ack);
            `CHK("data ack", 1'b0, ack)
            if (m < 8'hFC) mdl[m - 8'hF8] = d;
         end
         mst.stop;
         repeat (10) @(negedge i_mclk);
         `CHK("idle", 1'b1, idle)
         for (i = 0; i < 4; i++) `CHK("channel", mdl[i], ch[i])
         a = {5'b10010, strap, 1'b0};
         m = 8'hF8 | ($random(seed) & 8'h07);
         mst.start;
         mst.wbyte(a, ack);
         mst.wbyte(m, ack);
         mst.start;
         mst.wbyte(a | 8'h01, ack);
         mst.rbyte(1'b1, rd);
         `CHK("release", 1'b0, sda_oe)
         mst.stop;
         `CHK("read", (m < 8'hFC) ? mdl[m - 8'hF8] : 8'h00, rd)
      end
      // A second reset in mid-run must clear every setting again.
      i_srst = 1'b1;
      repeat (8) @(negedge i_mclk);
      i_srst = 1'b0;
      for (i = 0; i < 4; i++) mdl[i] = 8'h00;
      repeat (4) @(negedge i_mclk);
      `CHK("idle after reset", 1'b1, idle)
      for (i = 0; i < 4; i++) `CHK("reset again", mdl[i], ch[i])
      tally_and_finish;
   end
endmodule // icds_slave_tb
bind icds_slave icds_chk u_chk (.i_mclk(i_mclk), .i_srst(i_srst), .i_scl(i_scl),
   .i_sda(i_sda), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_bus_idle(o_bus_idle),
   .o_ch0_setting(o_ch0_setting), .o_ch1_setting(o_ch1_setting),
   .o_ch2_setting(o_ch2_setting), .o_ch3_setting(o_ch3_setting));
`default_nettype wire
